// *** bst_pkg.sv ***
// Constants, encodings and carrier types of the boundary-scan test logic.
// Assumes one system clock; test-port pins are sampled, not used as clocks.
package bst_pkg;

   // ---------------------------------------------------------------
   // Instruction codes
   // ---------------------------------------------------------------
   localparam int IR_W = 10;
   localparam logic [9:0] INS_BYPASS = 10'h3ff;
   localparam logic [9:0] INS_IDCODE = 10'h006;
   localparam logic [9:0] INS_SAMPLE = 10'h005;
   localparam logic [9:0] INS_EXTEST = 10'h00f;
   localparam logic [9:0] INS_HIGHZ = 10'h00b;
   localparam logic [9:0] INS_CLAMP = 10'h00a;
   localparam logic [9:0] INS_USERCODE = 10'h007;
   localparam logic [9:0] INS_PULSE_CFG = 10'h001;
   localparam logic [9:0] INS_CONFIG_IO = 10'h00d;
   // Pattern loaded in capture-IR, shifted out LSB first
   localparam logic [9:0] IR_CAPTURE = 10'h001;

   // ---------------------------------------------------------------
   // Data register selection
   // ---------------------------------------------------------------
   localparam logic [1:0] SEL_BYP = 2'h0;
   localparam logic [1:0] SEL_ID = 2'h1;
   localparam logic [1:0] SEL_BSR = 2'h2;

   // ---------------------------------------------------------------
   // Boundary cell layout
   // ---------------------------------------------------------------
   localparam int CELL_W = 3;
   localparam int CELL_OUT = 0;
   localparam int CELL_OE = 1;
   localparam int CELL_IN = 2;
   localparam logic DED_CAP_OUT = 1'b0;
   localparam logic DED_CAP_OE = 1'b1;

   // ---------------------------------------------------------------
   // Register map and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_USERCODE = 8'h04;
   localparam int ST_TAP_LSB = 0;
   localparam int ST_IR_LSB = 4;
   localparam int ST_HALT = 14;
   localparam int ST_REJECT = 15;
   localparam logic [31:0] USERCODE_RST = 32'hffff_ffff;
   // Identification value is arbitrary; only the LSB of one is meaningful
   localparam logic [31:0] IDCODE_DEF = 32'h0abc_d001;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
      TAP_SH_DR = 4'h6, TAP_EX1_DR = 4'h7, TAP_PAU_DR = 4'h5, TAP_EX2_DR = 4'h4,
      TAP_UP_DR = 4'hc, TAP_SEL_IR = 4'hd, TAP_CAP_IR = 4'hf, TAP_SH_IR = 4'he,
      TAP_EX1_IR = 4'ha, TAP_PAU_IR = 4'hb, TAP_EX2_IR = 4'h9, TAP_UP_IR = 4'h8
   } bst_tap_e;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic cfg_n;
   } bst_jtag_s;

   localparam bst_jtag_s JTAG_RST = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, cfg_n: 1'b1};

endpackage

// *** bst_chain.sv ***
// Serial boundary register: capture, shift and update stages of all cells.
// Assumes single-cycle strobes from the test controller in the same domain.
module bst_chain #(
   parameter int unsigned CELLS = 1
) (
   input wire logic hclk, // System clock
   input wire logic hresetn, // Async reset, active low
   input wire logic cap_en, // Load capture stages
   input wire logic sh_en, // Shift one place toward sdo
   input wire logic up_en, // Copy capture stages to update stages
   input wire logic sdi, // Serial data in
   input wire logic [CELLS*bst_pkg::CELL_W-1:0] cap_vec, // Capture values
   output logic sdo, // Serial data out
   output logic [CELLS*bst_pkg::CELL_W-1:0] upd_vec // Update stages
);
   localparam int unsigned W = CELLS * bst_pkg::CELL_W;

   typedef struct packed {
      logic [W-1:0] sh;
      logic [W-1:0] upd;
   } bst_chain_s;

   bst_chain_s q;
   bst_chain_s d;

   always_comb begin
      d = q;
      if (cap_en) begin
         d.sh = cap_vec;
      end else if (sh_en) begin
         d.sh = {sdi, q.sh[W-1:1]};
      end
      if (up_en) begin
         d.upd = q.sh;
      end
   end

   // Update stages start all ones: no cell drives before a preload
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q.sh <= '0;
         q.upd <= '1;
      end else begin
         q <= d;
      end
   end

   assign sdo = q.sh[0];
   assign upd_vec = q.upd;

endmodule

// *** bst_top.sv ***
// Boundary-scan test logic: test port controller, instruction, bypass,
// identification and boundary registers, plus an AHB-Lite status port.
// Assumes the test port pins are asynchronous and much slower than hclk.
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
module bst_top #(
   parameter int unsigned N_IO = 8,
   parameter int unsigned N_DIN = 2,
   parameter int unsigned N_OD = 1,
   parameter logic [N_IO-1:0] DIFF_MASK = '0,
   parameter logic [31:0] ID_CODE = bst_pkg::IDCODE_DEF
) (
   input wire logic hclk, // System clock, 250 MHz
   input wire logic hresetn, // Async reset, active low (power-up)
   input wire logic hsel, // AHB slave select
   input wire logic [31:0] haddr, // AHB address
   input wire logic [1:0] htrans, // AHB transfer type
   input wire logic hwrite, // AHB write
   input wire logic [31:0] hwdata, // AHB write data
   input wire logic hready, // AHB bus ready
   output logic [31:0] hrdata, // AHB read data
   output logic hreadyout, // AHB slave ready
   output logic hresp, // AHB response, always OKAY
   input wire logic tck, // Test clock pin
   input wire logic tms, // Test mode select pin
   input wire logic tdi, // Test data input pin
   output logic tdo, // Test data output value
   output logic tdo_oe_n, // Test data output enable, low drives
   input wire logic config_request_n, // Configuration request pin
   input wire logic config_busy, // Configuration in progress
   input wire logic config_done, // Device configured
   output logic config_halt, // Configuration held off by test
   output logic config_pulse, // One-cycle reconfiguration request
   input wire logic chip_clear_n, // Chip-wide clear, for the core only
   input wire logic chip_output_enable, // Chip-wide output enable
   output logic core_clear_n, // Registered chip clear to the core
   input wire logic [N_IO-1:0] core_output_value, // Core output data
   input wire logic [N_IO-1:0] core_output_enable_n, // Core output enable
   output logic [N_IO-1:0] cell_core_input_value, // Input data to core
   input wire logic [N_IO-1:0] pin_in, // User pin level
   output logic [N_IO-1:0] pin_out, // User pin drive value
   output logic [N_IO-1:0] pin_oe_n, // User pin enable, low drives
   input wire logic [N_DIN-1:0] ded_in, // Dedicated input pin levels
   input wire logic [N_OD-1:0] od_in, // Open-drain dedicated pin levels
   input wire logic [N_OD-1:0] od_core_oe_n // Open-drain core enable
);
   localparam int unsigned CELLS = N_IO + N_DIN + N_OD;
   localparam int unsigned PW = CELLS;
   localparam int unsigned BW = CELLS * bst_pkg::CELL_W;

   typedef struct packed {
      bst_pkg::bst_jtag_s s0;
      bst_pkg::bst_jtag_s s1;
      bst_pkg::bst_jtag_s s2;
      bst_pkg::bst_jtag_s flt;
      logic [PW-1:0] p0;
      logic [PW-1:0] p1;
      logic [PW-1:0] p2;
      logic [PW-1:0] pflt;
      bst_pkg::bst_tap_e tap;
      logic [9:0] ir_sh;
      logic [9:0] ir;
      logic byp;
      logic [31:0] dr_sh;
      logic tdo;
      logic tdo_oe_n;
      logic [N_IO-1:0] pin_out;
      logic [N_IO-1:0] pin_oe_n;
      logic [N_IO-1:0] core_in;
      logic core_clear_n;
      logic cfg_halt;
      logic cfg_pulse;
      logic reject;
      logic [31:0] usercode;
      logic wr_pend;
      logic [7:0] wr_ofs;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } bst_state_s;

   bst_state_s q;
   bst_state_s d;

   logic rise;
   logic fall;
   logic acc;
   logic [1:0] sel;
   logic [9:0] ins;
   logic cap_en;
   logic sh_en;
   logic up_en;
   logic test_drv;
   logic hiz;
   logic lock;
   logic [BW-1:0] cap_vec;
   logic [BW-1:0] upd_vec;
   logic chain_sdo;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic bst_pkg::bst_tap_e tap_next(input bst_pkg::bst_tap_e s, input logic m);
      unique case (s)
         bst_pkg::TAP_RESET: tap_next = m ? bst_pkg::TAP_RESET : bst_pkg::TAP_IDLE;
         bst_pkg::TAP_IDLE: tap_next = m ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
         bst_pkg::TAP_SEL_DR: tap_next = m ? bst_pkg::TAP_SEL_IR : bst_pkg::TAP_CAP_DR;
         bst_pkg::TAP_CAP_DR: tap_next = m ? bst_pkg::TAP_EX1_DR : bst_pkg::TAP_SH_DR;
         bst_pkg::TAP_SH_DR: tap_next = m ? bst_pkg::TAP_EX1_DR : bst_pkg::TAP_SH_DR;
         bst_pkg::TAP_EX1_DR: tap_next = m ? bst_pkg::TAP_UP_DR : bst_pkg::TAP_PAU_DR;
         bst_pkg::TAP_PAU_DR: tap_next = m ? bst_pkg::TAP_EX2_DR : bst_pkg::TAP_PAU_DR;
         bst_pkg::TAP_EX2_DR: tap_next = m ? bst_pkg::TAP_UP_DR : bst_pkg::TAP_SH_DR;
         bst_pkg::TAP_UP_DR: tap_next = m ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
         bst_pkg::TAP_SEL_IR: tap_next = m ? bst_pkg::TAP_RESET : bst_pkg::TAP_CAP_IR;
         bst_pkg::TAP_CAP_IR: tap_next = m ? bst_pkg::TAP_EX1_IR : bst_pkg::TAP_SH_IR;
         bst_pkg::TAP_SH_IR: tap_next = m ? bst_pkg::TAP_EX1_IR : bst_pkg::TAP_SH_IR;
         bst_pkg::TAP_EX1_IR: tap_next = m ? bst_pkg::TAP_UP_IR : bst_pkg::TAP_PAU_IR;
         bst_pkg::TAP_PAU_IR: tap_next = m ? bst_pkg::TAP_EX2_IR : bst_pkg::TAP_PAU_IR;
         bst_pkg::TAP_EX2_IR: tap_next = m ? bst_pkg::TAP_UP_IR : bst_pkg::TAP_SH_IR;
         bst_pkg::TAP_UP_IR: tap_next = m ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
      endcase
   endfunction

   // Unknown codes fall back to the bypass register
   function automatic logic [1:0] dr_sel(input logic [9:0] ir);
      unique case (ir)
         bst_pkg::INS_IDCODE, bst_pkg::INS_USERCODE: dr_sel = bst_pkg::SEL_ID;
         bst_pkg::INS_SAMPLE, bst_pkg::INS_EXTEST: dr_sel = bst_pkg::SEL_BSR;
         default: dr_sel = bst_pkg::SEL_BYP;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      cap_en = 1'b0;
      sh_en = 1'b0;
      up_en = 1'b0;
      ins = q.ir_sh;
      cap_vec = '0;

      // Three-stage sampling; a level counts once stages two and three agree
      d.s0 = '{tck: tck, tms: tms, tdi: tdi, cfg_n: config_request_n};
      d.s1 = q.s0;
      d.s2 = q.s1;
      d.flt = bst_pkg::bst_jtag_s'((~(q.s1 ^ q.s2) & q.s2) | ((q.s1 ^ q.s2) & q.flt));
      d.p0 = {od_in, ded_in, pin_in};
      d.p1 = q.p0;
      d.p2 = q.p1;
      d.pflt = (~(q.p1 ^ q.p2) & q.p2) | ((q.p1 ^ q.p2) & q.pflt);
      rise = d.flt.tck & ~q.flt.tck;
      fall = ~d.flt.tck & q.flt.tck;
      sel = dr_sel(q.ir);

      // Register port: zero wait, OKAY only, unmapped reads return zero
      d.hreadyout = 1'b1;
      d.hresp = 1'b0;
      d.hrdata = '0;
      acc = hsel & hready & htrans[1];
      d.wr_pend = acc & hwrite & (haddr[31:8] == 24'h00_0000);
      d.wr_ofs = haddr[7:0];
      if (acc && !hwrite && haddr[31:8] == 24'h00_0000) begin
         if (haddr[7:0] == bst_pkg::OFS_STATUS) begin
            d.hrdata[bst_pkg::ST_TAP_LSB +: 4] = q.tap;
            d.hrdata[bst_pkg::ST_IR_LSB +: 10] = q.ir;
            d.hrdata[bst_pkg::ST_HALT] = q.cfg_halt;
            d.hrdata[bst_pkg::ST_REJECT] = q.reject;
         end else if (haddr[7:0] == bst_pkg::OFS_USERCODE) begin
            d.hrdata = q.usercode;
         end
      end
      if (q.wr_pend) begin
         if (q.wr_ofs == bst_pkg::OFS_USERCODE) begin
            d.usercode = hwdata;
         end else if (q.wr_ofs == bst_pkg::OFS_STATUS && hwdata[bst_pkg::ST_REJECT]) begin
            d.reject = 1'b0;
         end
      end

      // Chip clear is only passed to the core; test state never sees it
      d.core_clear_n = chip_clear_n;
      d.cfg_pulse = 1'b0;
      if (!d.flt.cfg_n) begin
         d.cfg_halt = 1'b0;
      end

      // Rising test clock: sample inputs, capture and shift, advance
      if (rise) begin
         case (q.tap)
            bst_pkg::TAP_CAP_IR: d.ir_sh = bst_pkg::IR_CAPTURE;
            bst_pkg::TAP_SH_IR: d.ir_sh = {d.flt.tdi, q.ir_sh[9:1]};
            bst_pkg::TAP_CAP_DR: begin
               if (sel == bst_pkg::SEL_BYP) begin
                  d.byp = 1'b0;
               end else if (sel == bst_pkg::SEL_ID) begin
                  d.dr_sh = (q.ir == bst_pkg::INS_USERCODE) ? q.usercode : ID_CODE;
               end else begin
                  cap_en = 1'b1;
               end
            end
            bst_pkg::TAP_SH_DR: begin
               if (sel == bst_pkg::SEL_BYP) begin
                  d.byp = d.flt.tdi;
               end else if (sel == bst_pkg::SEL_ID) begin
                  d.dr_sh = {d.flt.tdi, q.dr_sh[31:1]};
               end else begin
                  sh_en = 1'b1;
               end
            end
            default: begin
            end
         endcase
         // Five high samples reach reset from any state
         d.tap = tap_next(q.tap, d.flt.tms);
      end

      // Falling test clock: drive output, update stages and instruction
      if (fall) begin
         d.tdo_oe_n = ~(q.tap == bst_pkg::TAP_SH_IR || q.tap == bst_pkg::TAP_SH_DR);
         if (q.tap == bst_pkg::TAP_SH_IR) begin
            d.tdo = q.ir_sh[0];
         end else if (sel == bst_pkg::SEL_BYP) begin
            d.tdo = q.byp;
         end else if (sel == bst_pkg::SEL_ID) begin
            d.tdo = q.dr_sh[0];
         end else begin
            d.tdo = chain_sdo;
         end
         if (q.tap == bst_pkg::TAP_UP_DR && sel == bst_pkg::SEL_BSR) begin
            up_en = 1'b1;
         end
         if (q.tap == bst_pkg::TAP_UP_IR) begin
            d.ir = ins;
            unique case (ins)
               // These three never disturb a running configuration
               bst_pkg::INS_BYPASS, bst_pkg::INS_IDCODE, bst_pkg::INS_SAMPLE: begin
               end
               bst_pkg::INS_CONFIG_IO: d.cfg_halt = 1'b1;
               bst_pkg::INS_PULSE_CFG: begin
                  d.cfg_pulse = 1'b1;
                  d.cfg_halt = 1'b0;
               end
               default: begin
                  // Pin-affecting tests refused while configuration runs
                  if (config_busy && !q.cfg_halt && d.flt.cfg_n) begin
                     d.ir = bst_pkg::INS_BYPASS;
                     d.reject = 1'b1;
                  end
               end
            endcase
         end
      end
      if (q.tap == bst_pkg::TAP_RESET) begin
         d.ir = bst_pkg::INS_IDCODE;
      end

      // Capture vector: user cells first, then dedicated inputs, then open drain
      for (int i = 0; i < N_IO; i++) begin
         cap_vec[i*bst_pkg::CELL_W + bst_pkg::CELL_OUT] = core_output_value[i];
         cap_vec[i*bst_pkg::CELL_W + bst_pkg::CELL_OE] = core_output_enable_n[i];
         cap_vec[i*bst_pkg::CELL_W + bst_pkg::CELL_IN] = q.pflt[i];
      end
      for (int i = N_IO; i < N_IO + N_DIN; i++) begin
         cap_vec[i*bst_pkg::CELL_W + bst_pkg::CELL_OUT] = bst_pkg::DED_CAP_OUT;
         cap_vec[i*bst_pkg::CELL_W + bst_pkg::CELL_OE] = bst_pkg::DED_CAP_OE;
         cap_vec[i*bst_pkg::CELL_W + bst_pkg::CELL_IN] = q.pflt[i];
      end
      for (int i = 0; i < N_OD; i++) begin
         cap_vec[(N_IO+N_DIN+i)*bst_pkg::CELL_W + bst_pkg::CELL_OUT] = bst_pkg::DED_CAP_OUT;
         cap_vec[(N_IO+N_DIN+i)*bst_pkg::CELL_W + bst_pkg::CELL_OE] = od_core_oe_n[i];
         cap_vec[(N_IO+N_DIN+i)*bst_pkg::CELL_W + bst_pkg::CELL_IN] = q.pflt[N_IO+N_DIN+i];
      end

      // Pin muxes; only user cells use their update stages
      test_drv = (q.ir == bst_pkg::INS_EXTEST) || (q.ir == bst_pkg::INS_CLAMP);
      hiz = (q.ir == bst_pkg::INS_HIGHZ);
      lock = 1'b0;
      for (int i = 0; i < N_IO; i++) begin
         lock = DIFF_MASK[i] & config_done;
         if (test_drv && !lock) begin
            d.pin_out[i] = upd_vec[i*bst_pkg::CELL_W + bst_pkg::CELL_OUT];
            d.pin_oe_n[i] = upd_vec[i*bst_pkg::CELL_W + bst_pkg::CELL_OE];
            d.core_in[i] = upd_vec[i*bst_pkg::CELL_W + bst_pkg::CELL_IN];
         end else begin
            d.pin_out[i] = core_output_value[i];
            // Chip enable gates only the functional path
            d.pin_oe_n[i] = (hiz && !lock) | core_output_enable_n[i] | ~chip_output_enable;
            d.core_in[i] = q.pflt[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // State register; power-up reset is the only asynchronous reset
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
         q.s0 <= bst_pkg::JTAG_RST;
         q.s1 <= bst_pkg::JTAG_RST;
         q.s2 <= bst_pkg::JTAG_RST;
         q.flt <= bst_pkg::JTAG_RST;
         q.tap <= bst_pkg::TAP_RESET;
         q.ir <= bst_pkg::INS_IDCODE;
         q.ir_sh <= bst_pkg::IR_CAPTURE;
         q.tdo_oe_n <= 1'b1;
         q.pin_oe_n <= '1;
         q.core_clear_n <= 1'b1;
         q.usercode <= bst_pkg::USERCODE_RST;
         q.hreadyout <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Boundary register, one three-bit cell per pin
   // ---------------------------------------------------------------
   bst_chain #(
      .CELLS(CELLS)
   ) u_chain (
      .hclk(hclk),
      .hresetn(hresetn),
      .cap_en(cap_en),
      .sh_en(sh_en),
      .up_en(up_en),
      .sdi(d.flt.tdi),
      .cap_vec(cap_vec),
      .sdo(chain_sdo),
      .upd_vec(upd_vec)
   );

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign hrdata = q.hrdata;
   assign hreadyout = q.hreadyout;
   assign hresp = q.hresp;
   assign tdo = q.tdo;
   assign tdo_oe_n = q.tdo_oe_n;
   assign config_halt = q.cfg_halt;
   assign config_pulse = q.cfg_pulse;
   assign core_clear_n = q.core_clear_n;
   assign pin_out = q.pin_out;
   assign pin_oe_n = q.pin_oe_n;
   assign cell_core_input_value = q.core_in;

endmodule

// *** bst_chk.sv ***
// Port checks for the boundary-scan test logic.
// Assumes a bind onto bst_top; test pins much slower than hclk.
module bst_chk (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Reset, active low
   input wire logic hreadyout, // Slave ready
   input wire logic hresp, // Response
   input wire logic tck, // Test clock pin
   input wire logic tdo, // Test data out
   input wire logic tdo_oe_n, // Test data enable
   input wire logic config_request_n, // Config request pin
   input wire logic config_halt, // Config held off
   input wire logic config_pulse, // Reconfig pulse
   input wire logic chip_clear_n, // Chip clear
   input wire logic chip_output_enable, // Chip output enable
   input wire logic core_clear_n // Core clear
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Pin falls reach tdo about 4 hclk later, well inside the low phase
   property p_oe_fall; $changed(tdo_oe_n) |-> !tck; endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("tdo enable moved with tck high");
   property p_tdo_fall; !tdo_oe_n && $changed(tdo) |-> !tck; endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved with tck high");
   property p_clr; $changed(chip_clear_n) |=> core_clear_n == $past(chip_clear_n); endproperty
   a_clr: assert property (p_clr) else $error("chip clear not passed to core");
   property p_coe; $changed(chip_output_enable) |=> $stable(tdo_oe_n)[*3]; endproperty
   a_coe: assert property (p_coe) else $error("chip enable disturbed test port");
   property p_pulse; config_pulse |=> !config_pulse; endproperty
   a_pulse: assert property (p_pulse) else $error("reconfig pulse too long");
   property p_req; !config_request_n [*8] |-> !config_halt; endproperty
   a_req: assert property (p_req) else $error("halt kept with request low");
   property p_pulse_halt; config_pulse |-> ##[0:1] !config_halt; endproperty
   a_pulse_halt: assert property (p_pulse_halt) else $error("halt kept after pulse");
   property p_ready; hreadyout && !hresp; endproperty
   a_ready: assert property (p_ready) else $error("port not ready or error");
endmodule

// *** bst_jtag_ctl.sv ***
// Behavioural external test controller on the four test pins.
// Assumes tck idles low between calls; tdo is read 28 ns after the rising edge, 4 ns before the fall.
module bst_jtag_ctl (
   output logic tck, // Test clock
   output logic tms, // Mode select
   output logic tdi, // Data to device
   input wire logic tdo, // Data from device
   input wire logic tdo_oe_n // Device tdo enable
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      tck <= 1'b0;
      tms <= 1'b1;
      tdi <= 1'b1;
   end
   // Non-blocking: a pin change that lands on an hclk edge is seen after it
   task automatic clk(input logic m, input logic d, output logic q);
      tms <= m;
      tdi <= d;
      #32 tck <= 1'b1;
      // Released line reads back inverted so stale data cannot pass
      #28 q = tdo_oe_n ? ~tdo : tdo;
      #4 tck <= 1'b0;
   endtask
   task automatic treset;
      logic q;
      repeat (5) clk(1'b1, 1'b1, q);
      clk(1'b0, 1'b1, q);
   endtask
   task automatic scan(input logic to_ir, input logic [63:0] v, input int n, output logic [63:0] r);
      logic q;
      r = '0;
      clk(1'b1, 1'b0, q);
      if (to_ir) clk(1'b1, 1'b0, q);
      clk(1'b0, 1'b0, q);
      clk(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         clk(i == n - 1, v[i], q);
         r[i] = q;
      end
      clk(1'b1, 1'b0, q);
      clk(1'b0, 1'b0, q);
   endtask
endmodule

// *** tb_boundary_scan_test_logic.sv ***
// Bench: status port over AHB-Lite plus scan traffic via the controller.
// Assumes 8 user, 2 dedicated, 1 open-drain cell; user cell 3 is a differential pin.
module tb_boundary_scan_test_logic;
   timeunit 1ns;
   timeprecision 100ps;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, busy = 0, done = 0, req_n = 1, clr_n = 1, coe = 1;
   logic hreadyout, hresp, tck, tms, tdi, tdo, tdo_oe_n, halt, pulse, saw_pulse = 0;
   logic [1:0] htrans = '0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [7:0] cov = 8'ha5, coen = 8'hff, pin_out, pin_oe_n, pins, core_in;
   logic [1:0] ded = 2'h2;
   logic [0:0] od = 1'h1, odoe = 1'h0;
   logic [63:0] r, v = '0, e = '0;
   int n_mismatch = 0, n_tests = 0;
   always #2 hclk = ~hclk;
   always @(posedge hclk) if (pulse) saw_pulse <= 1'b1;
   // Undriven pins float to a fixed pattern
   assign pins = ~pin_oe_n & pin_out | pin_oe_n & 8'h3c;
   bst_top #(.DIFF_MASK(8'h08)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tck(tck),
      .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .config_request_n(req_n), .config_busy(busy),
      .config_done(done), .config_halt(halt), .config_pulse(pulse), .chip_clear_n(clr_n),
      .chip_output_enable(coe), .core_clear_n(), .core_output_value(cov), .core_output_enable_n(coen),
      .cell_core_input_value(core_in), .pin_in(pins), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ded_in(ded),
      .od_in(od), .od_core_oe_n(odoe));
   bst_jtag_ctl ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
   task automatic print_verdict;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] s, input logic [63:0] x);
      n_tests++;
      if (s !== x) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, s, x);
      end
   endtask
   task automatic wt;
      int k;
      k = 0;
      do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 20);
      if (hreadyout !== 1'b1) begin n_mismatch++; print_verdict(); end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wt();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      wt();
      rd = hrdata;
   endtask
   task automatic ir(input logic [9:0] c);
      ctl.scan(1'b1, {54'h0, c}, 10, r);
   endtask
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, 32'h0, '0);
      chk(rd, {18'h0, bst_pkg::INS_IDCODE, 4'h0});
      ahb(1'b0, 32'h4, '0);
      chk(rd, bst_pkg::USERCODE_RST);
      ahb(1'b1, 32'h4, 32'h1234_5678);
      ahb(1'b0, 32'h4, '0);
      chk(rd, 32'h1234_5678);
      ahb(1'b0, 32'h100, '0);
      chk(rd, '0);
      clr_n <= 1'b0;
      coe <= 1'b0;
      #1.3 ctl.treset();
      ctl.scan(1'b0, '0, 32, r);
      chk(r[31:0], bst_pkg::IDCODE_DEF);
      busy <= 1'b1;
      ir(bst_pkg::INS_BYPASS);
      chk(r[9:0], bst_pkg::IR_CAPTURE);
      ctl.scan(1'b0, 64'h96, 8, r);
      chk(r[7:0], 8'h2c);
      ir(bst_pkg::INS_EXTEST);
      ahb(1'b0, 32'h0, '0);
      chk(rd, {16'h0, 2'b10, bst_pkg::INS_BYPASS, 4'h1});
      ahb(1'b1, 32'h0, 32'h8000);
      ahb(1'b0, 32'h0, '0);
      chk(rd[15], 1'b0);
      ir(bst_pkg::INS_CONFIG_IO);
      ir(bst_pkg::INS_SAMPLE);
      ahb(1'b0, 32'h0, '0);
      chk(rd[14:4], {1'b1, bst_pkg::INS_SAMPLE});
      for (int i = 0; i < 8; i++) begin
         v[3*i +: 3] = {1'b0, i > 3, i[0]};
         e[3*i +: 3] = {pins[i], coen[i], cov[i]};
      end
      e[32:24] = {od, odoe, 1'b0, ded[1], 2'b10, ded[0], 2'b10};
      ctl.scan(1'b0, v, 33, r);
      chk(r, e);
      ir(bst_pkg::INS_EXTEST);
      chk({pin_oe_n, pin_out & ~pin_oe_n}, 16'hf00a);
      ir(bst_pkg::INS_HIGHZ);
      chk(pin_oe_n, 8'hff);
      chk(core_in, 8'h3c);
      ir(bst_pkg::INS_PULSE_CFG);
      ahb(1'b0, 32'h0, '0);
      chk({saw_pulse, rd[14]}, 2'b10);
      done <= 1'b1;
      req_n <= 1'b0;
      ir(bst_pkg::INS_EXTEST);
      ahb(1'b0, 32'h0, '0);
      chk(rd[13:4], bst_pkg::INS_EXTEST);
      // Configured: differential cell 3 keeps core drive and pin input
      chk({pin_oe_n, pin_out & ~pin_oe_n, core_in}, 24'hf80208);
      ir(bst_pkg::INS_CLAMP);
      chk({pin_oe_n, core_in}, 16'hf808);
      ir(bst_pkg::INS_USERCODE);
      ctl.scan(1'b0, '0, 32, r);
      chk(r[31:0], 32'h1234_5678);
      print_verdict();
   end
endmodule
bind bst_top bst_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .tck(tck),
   .tdo(tdo), .tdo_oe_n(tdo_oe_n), .config_request_n(config_request_n), .config_halt(config_halt),
   .config_pulse(config_pulse), .chip_clear_n(chip_clear_n), .chip_output_enable(chip_output_enable),
   .core_clear_n(core_clear_n));
